/* core/esf_pkg.sv */
// Package of constants and types for the event status flag bank.
// Notes on behaviour
// RULE_01 - Left headphone over-current sets sticky bit, read clears.
// RULE_02 - Right headphone over-current sets sticky bit, read clears.
// RULE_03 - Button press latched sticky, cleared on read.
// RULE_04 - Any headset insert or remove latched, cleared on read.
// RULE_05 - Left/right compressor threshold crossings latched, read clears.
// RULE_06 - Left/right gain-control noise detections latched, read clears.
// RULE_07 - Left/right DC data-ready latched, read clears.
// RULE_08 - Reserved bits read zero; software writes defaults.
// RULE_09 - Live over-current and button state, no latching.
// RULE_10 - Live headset bit: one inserted, zero removed.
// RULE_11 - Live compressor above-threshold state per channel.
// RULE_12 - Live gain-control below-noise state per channel.
// RULE_13 - Live DC data-available state, not cleared.
// RULE_14 - Sticky read stops repeated two-millisecond pulse train.
// RULE_15 - Read clears only returned bits; same-cycle events kept.
// RULE_16 - Flag registers ignore all writes.
package esf_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_STICKY_A = 8'h2c;
    localparam logic [7:0] IDX_STICKY_B = 8'h2d;
    localparam logic [7:0] IDX_LIVE_A   = 8'h2e;
    localparam logic [7:0] IDX_LIVE_B   = 8'h2f;
    localparam logic [7:0] IDX_INT_CTRL = 8'h30;

    // Reset values of every register.
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;

    // Bit positions in the A registers.
    localparam int BIT_OVC_L   = 7;
    localparam int BIT_OVC_R   = 6;
    localparam int BIT_BUTTON  = 5;
    localparam int BIT_HEADSET = 4;
    localparam int BIT_DRC_L   = 3;
    localparam int BIT_DRC_R   = 2;

    // Bit positions in the B registers.
    localparam int BIT_NOISE_L = 6;
    localparam int BIT_NOISE_R = 5;
    localparam int BIT_DC_L    = 2;
    localparam int BIT_DC_R    = 1;

    // Bit positions in the interrupt control register.
    localparam int BIT_REPEAT  = 0;
    localparam int BIT_INT_EN  = 1;

    // Masks of implemented bits; all other bits read as zero.
    localparam logic [7:0] MASK_A    = 8'hfc;
    localparam logic [7:0] MASK_B    = 8'h66;
    localparam logic [7:0] MASK_CTRL = 8'h03;

    // Interrupt pulse width and clock rate.
    localparam int PULSE_MS  = 2;
    localparam int CLK_MHZ   = 100;
    localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
    localparam int PCNT_W    = 18;

    // Number of raw condition lines.
    localparam int COND_W = 10;

    // Present conditions reported by the analog and signal blocks.
    typedef struct packed {
        logic ovc_l;
        logic ovc_r;
        logic button;
        logic headset;
        logic drc_l;
        logic drc_r;
        logic noise_l;
        logic noise_r;
        logic dc_l;
        logic dc_r;
    } esf_cond_t;

    // States of the interrupt pulse generator.
    typedef enum logic [2:0] {
        PG_IDLE = 3'b001,
        PG_HIGH = 3'b010,
        PG_LOW  = 3'b100
    } esf_pg_state_t;

endpackage

/* core/esf_sync.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
module esf_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // First stage; only the second stage reads it.
    logic [W-1:0] meta_r;

    // Both stages reset to zero so flags start clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

/* core/esf_flag_bank.sv */
// Event status flag bank: sticky and live flag registers behind APB.
module esf_flag_bank #(
    parameter int PULSE_CYC = esf_pkg::PULSE_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire esf_pkg::esf_cond_t cond,
    output logic                   first_interrupt_output
);

    // Last count of a pulse phase (length minus one) as a counter-sized value.
    localparam logic [esf_pkg::PCNT_W-1:0] PULSE_LAST =
        esf_pkg::PCNT_W'(PULSE_CYC - 1);

    // Conditions after the two-stage synchroniser.
    esf_pkg::esf_cond_t cond_s;

    // Previous synchronised value, for edge detection.
    esf_pkg::esf_cond_t cond_q_r;

    // Sticky flag registers.
    logic [7:0] sticky_a_r;
    logic [7:0] sticky_b_r;

    // Sticky set terms for this cycle.
    logic [7:0] set_a;
    logic [7:0] set_b;

    // Live flag views.
    logic [7:0] live_a;
    logic [7:0] live_b;

    // Interrupt control register.
    logic [7:0] int_ctrl_r;

    // Bus decode.
    logic       acc_first;
    logic       acc_done;
    logic [9:0] word_idx;
    logic       hit_sticky_a;
    logic       hit_sticky_b;
    logic       hit_live_a;
    logic       hit_live_b;
    logic       hit_ctrl;
    logic       hit_any;
    logic [7:0] rd_val;

    // Latched decode of the transfer now in its access phase.
    logic [7:0] rd_mask_r;
    logic       rd_sticky_a_r;
    logic       rd_sticky_b_r;

    // Clear terms applied at the completing edge.
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic       sticky_read;

    // Pulse generator.
    esf_pkg::esf_pg_state_t   pg_state_r;
    logic [esf_pkg::PCNT_W-1:0] pg_cnt_r;
    logic                     new_event;
    logic                     pg_cnt_end;

    // Conditions arrive from other blocks without a common clock.
    // Each line is a slow level, so two flops suffice;
    // a pulse shorter than two clocks may be missed,
    // which the sending blocks must avoid.
    esf_sync #(
        .W (esf_pkg::COND_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cond),
        .q       (cond_s)
    );

    // Keep last cycle's synchronised value for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_q_r <= '0;
        end else begin
            cond_q_r <= cond_s;
        end
    end

    // Build the set terms for the first sticky register.
    // Over-current and threshold flags follow the level, so a long condition
    // re-sets the flag after a read; this matches "was detected" semantics.
    // Edge terms compare the synchronised value with its
    // one-cycle delay, so an edge-type event gives a
    // single-cycle set pulse two clocks after it lands.
    always_comb begin
        set_a = 8'h00;
        set_a[esf_pkg::BIT_OVC_L]   = cond_s.ovc_l;   // RULE_01
        set_a[esf_pkg::BIT_OVC_R]   = cond_s.ovc_r;   // RULE_02
        // A press is one event, so only its rising edge counts.
        set_a[esf_pkg::BIT_BUTTON]  = cond_s.button & ~cond_q_r.button; // RULE_03
        // Either edge of the headset level is an event of the same kind.
        set_a[esf_pkg::BIT_HEADSET] = cond_s.headset ^ cond_q_r.headset; // RULE_04
        set_a[esf_pkg::BIT_DRC_L]   = cond_s.drc_l;   // RULE_05
        set_a[esf_pkg::BIT_DRC_R]   = cond_s.drc_r;   // RULE_05
    end

    // Build the set terms for the second sticky register.
    always_comb begin
        set_b = 8'h00;
        set_b[esf_pkg::BIT_NOISE_L] = cond_s.noise_l; // RULE_06
        set_b[esf_pkg::BIT_NOISE_R] = cond_s.noise_r; // RULE_06
        set_b[esf_pkg::BIT_DC_L]    = cond_s.dc_l;    // RULE_07
        set_b[esf_pkg::BIT_DC_R]    = cond_s.dc_r;    // RULE_07
    end

    // Live view of the first group; nothing here is latched.
    // A read returns a level two clocks old; software that
    // needs the exact moment must use the sticky copy.
    always_comb begin
        live_a = 8'h00;
        live_a[esf_pkg::BIT_OVC_L]   = cond_s.ovc_l;   // RULE_09
        live_a[esf_pkg::BIT_OVC_R]   = cond_s.ovc_r;   // RULE_09
        live_a[esf_pkg::BIT_BUTTON]  = cond_s.button;  // RULE_09
        live_a[esf_pkg::BIT_HEADSET] = cond_s.headset; // RULE_10
        live_a[esf_pkg::BIT_DRC_L]   = cond_s.drc_l;   // RULE_11
        live_a[esf_pkg::BIT_DRC_R]   = cond_s.drc_r;   // RULE_11
    end

    // Live view of the second group.
    always_comb begin
        live_b = 8'h00;
        live_b[esf_pkg::BIT_NOISE_L] = cond_s.noise_l; // RULE_12
        live_b[esf_pkg::BIT_NOISE_R] = cond_s.noise_r; // RULE_12
        live_b[esf_pkg::BIT_DC_L]    = cond_s.dc_l;    // RULE_13
        live_b[esf_pkg::BIT_DC_R]    = cond_s.dc_r;    // RULE_13
    end

    // Phase decode. One wait state: the first access cycle fetches the
    // data, the second completes the transfer.
    // The wait state costs a cycle per transfer but lets
    // the clear mask come from a registered copy of the
    // returned word instead of a long combinational path.
    assign acc_first = psel & penable & ~pready;
    assign acc_done  = psel & penable & pready;
    assign word_idx  = paddr[11:2];

    // Address decode; low address bits must be zero for a hit.
    // The full word index is compared, so no register
    // appears at an alias address.
    always_comb begin
        hit_sticky_a = (paddr[1:0] == 2'b00) && (word_idx == {2'b00, esf_pkg::IDX_STICKY_A});
        hit_sticky_b = (paddr[1:0] == 2'b00) && (word_idx == {2'b00, esf_pkg::IDX_STICKY_B});
        hit_live_a   = (paddr[1:0] == 2'b00) && (word_idx == {2'b00, esf_pkg::IDX_LIVE_A});
        hit_live_b   = (paddr[1:0] == 2'b00) && (word_idx == {2'b00, esf_pkg::IDX_LIVE_B});
        hit_ctrl     = (paddr[1:0] == 2'b00) && (word_idx == {2'b00, esf_pkg::IDX_INT_CTRL});
        hit_any      = hit_sticky_a | hit_sticky_b | hit_live_a | hit_live_b | hit_ctrl;
    end

    // Read multiplexer; reserved bits are masked to zero.
    // Masking here as well as in the registers keeps
    // reserved bits at zero if a mask grows later.
    always_comb begin
        rd_val = 8'h00;
        if (hit_sticky_a) begin
            rd_val = sticky_a_r & esf_pkg::MASK_A; // RULE_08
        end else if (hit_sticky_b) begin
            rd_val = sticky_b_r & esf_pkg::MASK_B; // RULE_08
        end else if (hit_live_a) begin
            rd_val = live_a & esf_pkg::MASK_A;     // RULE_08
        end else if (hit_live_b) begin
            rd_val = live_b & esf_pkg::MASK_B;     // RULE_08
        end else if (hit_ctrl) begin
            rd_val = int_ctrl_r & esf_pkg::MASK_CTRL;
        end
    end

    // Ready toggles high for exactly the completing access cycle.
    // No transfer stretches past one wait state, so the
    // master never needs a timeout against this slave.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_first;
        end
    end

    // Read data and error are captured on the first access cycle and held
    // through completion, so the master samples a stable word.
    // Clearing the data after completion keeps the bus
    // quiet between transfers, which eases tracing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc_first) begin
            prdata  <= (!pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            pslverr <= ~hit_any;
        end else if (acc_done) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Remember exactly which bits were returned, for the clear.
    // The mask is the word that left on the bus, so a bit
    // set after the fetch survives for the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_mask_r     <= 8'h00;
            rd_sticky_a_r <= 1'b0;
            rd_sticky_b_r <= 1'b0;
        end else if (acc_first) begin
            rd_mask_r     <= rd_val;                 // RULE_15
            rd_sticky_a_r <= ~pwrite & hit_sticky_a;
            rd_sticky_b_r <= ~pwrite & hit_sticky_b;
        end else if (acc_done) begin
            rd_mask_r     <= 8'h00;
            rd_sticky_a_r <= 1'b0;
            rd_sticky_b_r <= 1'b0;
        end
    end

    // Clear terms: only at the completing edge, only returned bits.
    // An event that sets after the data was fetched is not in the mask.
    assign clr_a       = (acc_done && rd_sticky_a_r) ? rd_mask_r : 8'h00; // RULE_15
    assign clr_b       = (acc_done && rd_sticky_b_r) ? rd_mask_r : 8'h00; // RULE_15
    assign sticky_read = acc_done & (rd_sticky_a_r | rd_sticky_b_r);

    // First sticky register. Set wins over clear; writes never reach it.
    // Reserved bits are masked on every update, so no
    // stray term can ever set them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_a_r <= esf_pkg::RST_FLAGS;
        end else begin
            sticky_a_r <= ((sticky_a_r & ~clr_a) | set_a) & esf_pkg::MASK_A; // RULE_01 RULE_15 RULE_16
        end
    end

    // Second sticky register, same policy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_b_r <= esf_pkg::RST_FLAGS;
        end else begin
            sticky_b_r <= ((sticky_b_r & ~clr_b) | set_b) & esf_pkg::MASK_B; // RULE_06 RULE_15 RULE_16
        end
    end

    // Interrupt control is the only writable register. Writes to the flag
    // registers complete normally but change nothing.
    // Only the low byte of the write data is used; the
    // upper bits are ignored rather than refused.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ctrl_r <= esf_pkg::RST_INT_CTRL;
        end else if (acc_done && pwrite && hit_ctrl) begin
            int_ctrl_r <= pwdata[7:0] & esf_pkg::MASK_CTRL; // RULE_16
        end
    end

    // A new event is a flag going from clear to set.
    // A flag already set raises no new event, so a long
    // condition gives one interrupt, since a read cannot clear it.
    assign new_event = int_ctrl_r[esf_pkg::BIT_INT_EN] &
                       (|(set_a & ~sticky_a_r) | |(set_b & ~sticky_b_r));
    assign pg_cnt_end = (pg_cnt_r == PULSE_LAST);

    // Pulse generator. Single mode gives one pulse; repeat mode alternates
    // high and low phases of equal length until a sticky register is read.
    // Clearing the repeat bit mid-train lets the current or next
    // high phase run out and then stops the train.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_state_r <= esf_pkg::PG_IDLE;
        end else begin
            unique case (pg_state_r)
                esf_pkg::PG_IDLE: begin
                    if (new_event) begin
                        pg_state_r <= esf_pkg::PG_HIGH;
                    end
                end
                esf_pkg::PG_HIGH: begin
                    if (sticky_read && int_ctrl_r[esf_pkg::BIT_REPEAT]) begin
                        pg_state_r <= esf_pkg::PG_IDLE; // RULE_14
                    end else if (pg_cnt_end) begin
                        pg_state_r <= int_ctrl_r[esf_pkg::BIT_REPEAT] ? esf_pkg::PG_LOW : esf_pkg::PG_IDLE;
                    end
                end
                esf_pkg::PG_LOW: begin
                    if (sticky_read) begin
                        pg_state_r <= esf_pkg::PG_IDLE; // RULE_14
                    end else if (pg_cnt_end) begin
                        pg_state_r <= esf_pkg::PG_HIGH;
                    end
                end
                default: begin
                    pg_state_r <= esf_pkg::PG_IDLE;
                end
            endcase
        end
    end

    // Phase counter restarts on every state change.
    // In single mode a sticky read leaves the state alone,
    // so it must not restart the count either, or the
    // pulse would stretch past its set length.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_cnt_r <= '0;
        end else if (pg_state_r == esf_pkg::PG_IDLE || pg_cnt_end ||
                     (sticky_read && int_ctrl_r[esf_pkg::BIT_REPEAT])) begin
            pg_cnt_r <= '0;
        end else begin
            pg_cnt_r <= pg_cnt_r + 1'b1;
        end
    end

    // Output follows the next state so it comes straight from a flop.
    // Decoding the next state twice costs some logic,
    // traded for an output with no glitch path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_interrupt_output <= 1'b0;
        end else begin
            unique case (pg_state_r)
                esf_pkg::PG_IDLE: begin
                    first_interrupt_output <= new_event;
                end
                esf_pkg::PG_HIGH: begin
                    first_interrupt_output <= ~((sticky_read && int_ctrl_r[esf_pkg::BIT_REPEAT]) || pg_cnt_end);
                end
                esf_pkg::PG_LOW: begin
                    first_interrupt_output <= ~sticky_read && pg_cnt_end; // RULE_14
                end
                default: begin
                    first_interrupt_output <= 1'b0;
                end
            endcase
        end
    end

endmodule

/* bench/esf_flag_bank_properties.sv */
// Concurrent checks on the ports of the event status flag bank.
module esf_flag_bank_properties #(
    parameter int PULSE_CYC = 8
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire esf_pkg::esf_cond_t cond,
    input wire logic               first_interrupt_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    esf_pkg::esf_cond_t cond_q_r; // Previous condition sample.
    logic [2:0]         stab_r;   // Cycles the conditions have held still, saturating.
    logic [7:0]         ok_mask;  // Implemented bits of the addressed register.
    logic               rd_done;  // A read completes in this cycle.
    logic [31:0]        hi_r;     // Cycles the interrupt output has stood high so far.

    // Count quiet cycles so that live checks wait out the input synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_r   <= 3'h0;
            cond_q_r <= '0;
            hi_r     <= 32'h0;
        end else begin
            cond_q_r <= cond;
            hi_r     <= first_interrupt_output ? hi_r + 32'h1 : 32'h0;
            if (cond != cond_q_r) begin
                stab_r <= 3'h0;
            end else if (stab_r != 3'h7) begin
                stab_r <= stab_r + 3'h1;
            end
        end
    end

    // Unmapped and misaligned addresses have no implemented bits.
    always_comb begin
        case (paddr)
            12'h0b0, 12'h0b8: ok_mask = 8'hfc;
            12'h0b4, 12'h0bc: ok_mask = 8'h66;
            12'h0c0:          ok_mask = 8'h03;
            default:          ok_mask = 8'h00;
        endcase
    end
    assign rd_done = psel && penable && pready && !pwrite;

    AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("Access phase did not end after one wait state.");
    AST_PREADY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
        else $error("Ready outside an access or held too long.");
    AST_IDLE_QUIET: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("Read data or error driven outside the completing cycle.");
    AST_RSVD_ZERO: assert property (rd_done |-> (prdata & ~{24'h00_0000, ok_mask}) == 32'h0000_0000)
        else $error("Reserved bit read as one.");
    AST_LIVE_A: assert property (rd_done && paddr == 12'h0b8 && stab_r >= 3'h4 |->
        prdata[7:2] == {cond.ovc_l, cond.ovc_r, cond.button, cond.headset, cond.drc_l, cond.drc_r})
        else $error("First live register differs from the present conditions.");
    AST_LIVE_B: assert property (rd_done && paddr == 12'h0bc && stab_r >= 3'h4 |->
        {prdata[6:5], prdata[2:1]} == {cond.noise_l, cond.noise_r, cond.dc_l, cond.dc_r})
        else $error("Second live register differs from the present conditions.");
    AST_STICKY_A_HIGH: assert property (rd_done && paddr == 12'h0b0 && stab_r >= 3'h4 |->
        (prdata[7:6] & {cond.ovc_l, cond.ovc_r}) == {cond.ovc_l, cond.ovc_r}
        && (prdata[3:2] & {cond.drc_l, cond.drc_r}) == {cond.drc_l, cond.drc_r})
        else $error("First sticky register misses a standing event.");
    AST_STICKY_B_HIGH: assert property (rd_done && paddr == 12'h0b4 && stab_r >= 3'h4 |->
        (prdata[6:5] & {cond.noise_l, cond.noise_r}) == {cond.noise_l, cond.noise_r}
        && (prdata[2:1] & {cond.dc_l, cond.dc_r}) == {cond.dc_l, cond.dc_r})
        else $error("Second sticky register misses a standing event.");
    AST_MAPPED_OK: assert property (pready && ok_mask != 8'h00 |-> !pslverr)
        else $error("Mapped register answered with an error.");
    AST_UNMAPPED_ERR: assert property (psel && penable && pready && ok_mask == 8'h00 |-> pslverr)
        else $error("Unmapped address answered without an error.");
    AST_PULSE_MAX: assert property (first_interrupt_output |-> hi_r < 32'(PULSE_CYC))
        else $error("Interrupt pulse longer than its set length.");
endmodule

bind esf_flag_bank esf_flag_bank_properties #(.PULSE_CYC(PULSE_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond(cond),
    .first_interrupt_output(first_interrupt_output));

/* bench/testbench.sv */
// Self-checking testbench for the event status flag bank.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 8; // A short pulse keeps the interrupt test brief.
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, prev;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    esf_pkg::esf_cond_t cond, c;  // Driven conditions and the model's copy.
    logic [7:0]         sa, sb, ctl; // Model images of the sticky and control registers.
    logic [11:0]        bad [3] = '{12'h0ac, 12'h0b2, 12'h0c4};
    int                 mismatches, checks, seed, i, n, hcnt;

    esf_flag_bank #(.PULSE_CYC(PC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond(cond), .first_interrupt_output(irq));

    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Count interrupt high cycles for the pulse-length check.
    always @(posedge pclk) begin
        if (irq === 1'b1) hcnt <= hcnt + 1;
    end

    // Level-type events stay set while their condition is high.
    function automatic logic [7:0] lvl_a(input esf_pkg::esf_cond_t v);
        return {v.ovc_l, v.ovc_r, 2'b00, v.drc_l, v.drc_r, 2'b00};
    endfunction
    function automatic logic [7:0] lvl_b(input esf_pkg::esf_cond_t v);
        return {1'b0, v.noise_l, v.noise_r, 2'b00, v.dc_l, v.dc_r, 1'b0};
    endfunction
    function automatic logic [31:0] exp_of(input logic [11:0] a);
        case (a)
            12'h0b0: return {24'h00_0000, sa};
            12'h0b4: return {24'h00_0000, sb};
            12'h0b8: return {24'h00_0000, c.ovc_l, c.ovc_r, c.button, c.headset, c.drc_l, c.drc_r, 2'b00};
            12'h0bc: return {24'h00_0000, lvl_b(c)};
            default: return {24'h00_0000, ctl};
        endcase
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One transfer; the wait for ready is bounded so a dead slave cannot hang the run.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            rd = prdata;
            er = pslverr;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        @(posedge pclk);
    endtask

    // Read and compare, then let the model forget what the read returned.
    task automatic chk(input logic [11:0] a);
        logic [31:0] e;
        e = exp_of(a);
        apb(a, 1'b0, 32'h0000_0000);
        cmp(rd, e, "read data");
        cmp({31'h0, er}, 32'h0000_0000, "error flag");
        if (a == 12'h0b0) sa = lvl_a(c);
        if (a == 12'h0b4) sb = lvl_b(c);
    endtask

    // Button latches on press only, headset on either edge; the wait covers the synchroniser.
    task automatic set_cond(input esf_pkg::esf_cond_t v);
        cond <= v;
        sa = sa | lvl_a(v) | {2'b00, v.button & ~c.button, v.headset ^ c.headset, 4'h0};
        sb = sb | lvl_b(v);
        c = v;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        {mismatches, checks, sa, sb, ctl} = '0;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        cond = '0;
        c = '0;
        seed = 32'h571ca1e1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i++) chk(12'h0b0 + 12'(4 * i));
        foreach (bad[j]) begin
            apb(bad[j], 1'b0, 32'h0000_0000);
            cmp({31'h0, er}, 32'h0000_0001, "unmapped error");
        end
        // Random events, with repeated sticky reads to see them clear.
        for (n = 0; n < 40; n++) begin
            set_cond(esf_pkg::esf_cond_t'(10'($random(seed))));
            for (i = 0; i < 6; i++) chk(12'h0b0 + 12'(4 * (i % 4)));
        end
        // Writes to the flag registers must leave them untouched.
        set_cond(esf_pkg::esf_cond_t'(10'h2aa));
        for (i = 0; i < 4; i++) apb(12'h0b0 + 12'(4 * i), 1'b1, i[0] ? 32'h0000_0000 : 32'h0000_00fc);
        for (i = 0; i < 4; i++) chk(12'h0b0 + 12'(4 * i));
        // Repeating interrupt runs until a sticky read.
        set_cond('0);
        chk(12'h0b0);
        chk(12'h0b4);
        apb(12'h0c0, 1'b1, 32'h0000_0003);
        ctl = 8'h03;
        chk(12'h0c0);
        set_cond(esf_pkg::esf_cond_t'(10'h200));
        set_cond('0);
        n = 0;
        prev = irq;
        repeat (4 * PC) begin
            @(posedge pclk);
            if (irq === 1'b1 && prev !== 1'b1) n++;
            prev = irq;
        end
        cmp(32'(n > 1), 32'h0000_0001, "pulse train");
        chk(12'h0b0);
        @(posedge pclk);
        n = 0;
        repeat (3 * PC) begin
            @(posedge pclk);
            if (irq !== 1'b0) n++;
        end
        cmp(32'(n), 32'h0000_0000, "train stopped");
        // A single pulse keeps its length when a sticky read lands inside it.
        apb(12'h0c0, 1'b1, 32'h0000_0002);
        ctl = 8'h02;
        n = hcnt;
        set_cond(esf_pkg::esf_cond_t'(10'h200));
        chk(12'h0b0);
        repeat (2 * PC) @(posedge pclk);
        cmp(32'(hcnt - n), 32'(PC), "single pulse");
        end_sim();
    end
endmodule
